// File: logic/countdown_guard.sv
// Purpose: Countdown watchdog with APB registers and event channels
// Assumes: Sleep, halt and osc status inputs are asynchronous pins
// Notes:   APB answers with zero wait states; pslverr on unmapped address
`timescale 1ns/10ps
`default_nettype none
module countdown_guard (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpu_sleeping,
  input  wire logic        cpu_halted,
  input  wire logic        other_lf_running,
  input  wire logic        chan_event_valid,
  input  wire logic [7:0]  chan_event_index,
  output logic             chan_publish_valid,
  output logic [7:0]       chan_publish_index,
  output logic             expiry_irq,
  output logic             rc_osc_force,
  output logic             wdt_reset_req
);

  // **********************************************
  // State
  // **********************************************
  typedef struct packed {
    countdown_guard_pkg::guard_state_e fsm;
    logic [31:0] count;
    logic [31:0] counter_reload_value;
    logic [7:0]  reload_request_enable;
    logic [7:0]  keyed;
    logic [1:0]  pause;
    logic        sub_en;
    logic [7:0]  sub_ch;
    logic        pub_en;
    logic [7:0]  pub_ch;
    logic        irq_en;
    logic        flag;
    logic [1:0]  delay;
    logic [2:0]  sleep_sync;
    logic [2:0]  halt_sync;
    logic [2:0]  osc_sync;
    logic        sleep_q;
    logic        halt_q;
    logic        osc_q;
    logic [31:0] rdata;
    logic        slverr;
    logic        ready;
    logic        pub_valid;
    logic        irq;
    logic        osc_force;
    logic        rst_req;
  } guard_s;

  guard_s st_reg;
  guard_s st_next;
  logic   lf_tick;

  // **********************************************
  // Low-frequency tick
  // **********************************************
  lf_tick_if lf ();
  lf_tick_div u_div (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .lf      (lf)
  );
  assign lf_tick = lf.tick;

  // **********************************************
  // Helpers
  // **********************************************
  // Packs a channel register: enable at the top, index in the low byte
  function automatic logic chan_reg(input logic en, input logic [7:0] ch, output logic [31:0] v);
    v = 32'h00000000;
    v[countdown_guard_pkg::CH_EN_BIT] = en;
    v[7:0] = ch;
    return en;
  endfunction : chan_reg

  // **********************************************
  // Next state
  // **********************************************
  logic        setup;
  logic        wr;
  logic        rd;
  logic        running;
  logic        paused;
  logic        grant;
  logic        start;
  logic        mapped;
  logic [7:0]  rr_hit;
  logic [7:0]  pending;
  logic [2:0]  rr_idx;
  logic [31:0] rv;
  logic        unused_en;

  always_comb begin
    st_next   = st_reg;
    rv        = 32'h00000000;
    unused_en = 1'b0;
    rr_hit    = 8'h00;
    rr_idx    = paddr[4:2];
    setup     = psel && !penable;
    // Writes land at the access edge, where pready is sampled high
    wr        = psel && penable && st_reg.ready && pwrite;
    rd        = setup && !pwrite;
    running   = st_reg.fsm != countdown_guard_pkg::ST_STOPPED;
    pending   = st_reg.reload_request_enable & ~st_reg.keyed;

    // **********************************************
    // Pin synchronisers
    // **********************************************
    st_next.sleep_sync = {st_reg.sleep_sync[1:0], cpu_sleeping};
    st_next.halt_sync  = {st_reg.halt_sync[1:0], cpu_halted};
    st_next.osc_sync   = {st_reg.osc_sync[1:0], other_lf_running};
    if (st_reg.sleep_sync[1] == st_reg.sleep_sync[2]) begin
      st_next.sleep_q = st_reg.sleep_sync[2];
    end
    if (st_reg.halt_sync[1] == st_reg.halt_sync[2]) begin
      st_next.halt_q = st_reg.halt_sync[2];
    end
    if (st_reg.osc_sync[1] == st_reg.osc_sync[2]) begin
      st_next.osc_q = st_reg.osc_sync[2];
    end

    // Pause bit 0 means pause in that CPU state
    paused = (st_reg.sleep_q && !st_reg.pause[countdown_guard_pkg::PAUSE_SLEEP_BIT]) ||
             (st_reg.halt_q && !st_reg.pause[countdown_guard_pkg::PAUSE_HALT_BIT]);

    // **********************************************
    // Register read decode
    // **********************************************
    mapped = 1'b1;
    unique case (paddr)
      countdown_guard_pkg::OFS_START:     rv = 32'h00000000;
      countdown_guard_pkg::OFS_SUB:       unused_en = chan_reg(st_reg.sub_en, st_reg.sub_ch, rv);
      countdown_guard_pkg::OFS_FLAG:      rv = {31'h00000000, st_reg.flag};
      countdown_guard_pkg::OFS_PUB:       unused_en = chan_reg(st_reg.pub_en, st_reg.pub_ch, rv);
      countdown_guard_pkg::OFS_IRQ_SET,
      countdown_guard_pkg::OFS_IRQ_CLR:   rv = {31'h00000000, st_reg.irq_en};
      countdown_guard_pkg::OFS_RUN:       rv = {31'h00000000, running};
      countdown_guard_pkg::OFS_REQ_STATE: rv = {24'h000000, pending};
      countdown_guard_pkg::OFS_CRV:       rv = st_reg.counter_reload_value;
      countdown_guard_pkg::OFS_RELOAD_REQUEST_ENABLE:      rv = {24'h000000, st_reg.reload_request_enable};
      countdown_guard_pkg::OFS_PAUSE: begin
        rv[countdown_guard_pkg::PAUSE_SLEEP_BIT] = st_reg.pause[countdown_guard_pkg::PAUSE_SLEEP_BIT];
        rv[countdown_guard_pkg::PAUSE_HALT_POS]  = st_reg.pause[countdown_guard_pkg::PAUSE_HALT_BIT];
      end
      default: begin
        if (paddr >= countdown_guard_pkg::OFS_RR_BASE && paddr <= countdown_guard_pkg::OFS_RR_LAST &&
            paddr[1:0] == 2'h0) begin
          rv = 32'h00000000;
          rr_hit[rr_idx] = wr;
        end else begin
          mapped = 1'b0;
        end
      end
    endcase

    st_next.ready  = setup;
    st_next.slverr = setup && !mapped;
    st_next.rdata  = (rd && mapped) ? rv : 32'h00000000;
    start = (wr && paddr == countdown_guard_pkg::OFS_START && pwdata[0]) ||
            (st_reg.sub_en && chan_event_valid && chan_event_index == st_reg.sub_ch);

    // **********************************************
    // Register writes
    // **********************************************
    if (wr) begin
      unique case (paddr)
        countdown_guard_pkg::OFS_SUB: begin
          st_next.sub_en = pwdata[countdown_guard_pkg::CH_EN_BIT];
          st_next.sub_ch = pwdata[7:0];
        end
        countdown_guard_pkg::OFS_PUB: begin
          st_next.pub_en = pwdata[countdown_guard_pkg::CH_EN_BIT];
          st_next.pub_ch = pwdata[7:0];
        end
        countdown_guard_pkg::OFS_FLAG:    st_next.flag = pwdata[0];
        countdown_guard_pkg::OFS_IRQ_SET: st_next.irq_en = st_reg.irq_en | pwdata[0];
        countdown_guard_pkg::OFS_IRQ_CLR: st_next.irq_en = st_reg.irq_en & ~pwdata[0];
        countdown_guard_pkg::OFS_CRV: begin
          if (!running) begin
            st_next.counter_reload_value = pwdata;
          end
        end
        countdown_guard_pkg::OFS_RELOAD_REQUEST_ENABLE: begin
          if (!running) begin
            st_next.reload_request_enable = pwdata[7:0];
          end
        end
        countdown_guard_pkg::OFS_PAUSE: begin
          if (!running) begin
            st_next.pause = {pwdata[countdown_guard_pkg::PAUSE_HALT_POS],
                             pwdata[countdown_guard_pkg::PAUSE_SLEEP_BIT]};
          end
        end
        default: begin
        end
      endcase
    end

    // **********************************************
    // Reload requests
    // **********************************************
    // Key must match; recorded until grant
    if (running && pwdata == countdown_guard_pkg::RELOAD_KEY) begin
      st_next.keyed = st_reg.keyed | (rr_hit & st_reg.reload_request_enable);
    end
    grant = running && st_reg.reload_request_enable != 8'h00 && (st_next.keyed & st_reg.reload_request_enable) == st_reg.reload_request_enable;

    st_next.pub_valid = 1'b0;
    st_next.irq       = st_reg.flag && st_reg.irq_en;
    st_next.osc_force = running && !st_reg.osc_q;

    // **********************************************
    // Watchdog sequencer
    // **********************************************
    unique case (st_reg.fsm)
      countdown_guard_pkg::ST_STOPPED: begin
        if (start) begin
          st_next.fsm   = countdown_guard_pkg::ST_RUNNING;
          st_next.count = st_reg.counter_reload_value;
          st_next.keyed = 8'h00;
        end
      end

      countdown_guard_pkg::ST_RUNNING: begin
        if (grant) begin
          st_next.count = st_reg.counter_reload_value;
          st_next.keyed = 8'h00;
        end else if (lf_tick && !paused) begin
          if (st_reg.count == 32'h00000000) begin
            // Zero lasts one tick, so period is crv plus one ticks
            st_next.flag      = 1'b1;
            st_next.pub_valid = st_reg.pub_en;
            if (st_reg.irq_en) begin
              st_next.fsm   = countdown_guard_pkg::ST_DELAY;
              st_next.delay = countdown_guard_pkg::IRQ_RESET_DELAY;
            end else begin
              st_next.fsm     = countdown_guard_pkg::ST_RESET;
              st_next.rst_req = 1'b1;
            end
          end else begin
            st_next.count = st_reg.count - 32'h00000001;
          end
        end
      end

      countdown_guard_pkg::ST_DELAY: begin
        if (lf_tick) begin
          st_next.delay = st_reg.delay - 2'h1;
          if (st_reg.delay == 2'h1) begin
            st_next.fsm     = countdown_guard_pkg::ST_RESET;
            st_next.rst_req = 1'b1;
          end
        end
      end

      countdown_guard_pkg::ST_RESET: begin
        st_next.rst_req = 1'b1;
      end
    endcase
  end

  // **********************************************
  // State register
  // **********************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.fsm   <= countdown_guard_pkg::ST_STOPPED;
      st_reg.counter_reload_value   <= countdown_guard_pkg::CRV_RESET;
      st_reg.reload_request_enable  <= countdown_guard_pkg::RELOAD_REQUEST_ENABLE_RESET;
      st_reg.pause <= countdown_guard_pkg::PAUSE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // **********************************************
  // Outputs
  // **********************************************
  assign prdata             = st_reg.rdata;
  assign pready             = st_reg.ready;
  assign pslverr            = st_reg.slverr;
  assign chan_publish_valid = st_reg.pub_valid;
  assign chan_publish_index = st_reg.pub_ch;
  assign expiry_irq         = st_reg.irq;
  assign rc_osc_force       = st_reg.osc_force;
  assign wdt_reset_req      = st_reg.rst_req;

  // **********************************************
  // Checks
  // **********************************************
  chk_reset_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(wdt_reset_req) |=> wdt_reset_req [*8]) else $error("reset request dropped");
  chk_crv_locked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm != countdown_guard_pkg::ST_STOPPED) |=> $stable(st_reg.counter_reload_value)) else $error("crv changed while running");
  chk_reload_request_enable_locked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm != countdown_guard_pkg::ST_STOPPED) |=> $stable(st_reg.reload_request_enable)) else $error("reload_request_enable changed while running");
  chk_start_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == countdown_guard_pkg::ST_STOPPED && start) |=> st_reg.count == $past(st_reg.counter_reload_value)) else $error("no load on start");
  chk_grant_reload: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == countdown_guard_pkg::ST_RUNNING && grant) |=> st_reg.count == st_reg.counter_reload_value && st_reg.keyed == 8'h00) else $error("no reload");
  chk_no_irq_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ($rose(st_reg.flag) && st_reg.fsm == countdown_guard_pkg::ST_RESET) |-> wdt_reset_req) else $error("reset late");
  chk_irq_delay: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == countdown_guard_pkg::ST_DELAY) |-> !wdt_reset_req) else $error("reset too early");
  chk_run_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (psel && !penable && !pwrite && paddr == countdown_guard_pkg::OFS_RUN) |=>
    prdata[0] == ($past(st_reg.fsm) != countdown_guard_pkg::ST_STOPPED)) else $error("run indicator wrong");
  chk_pause_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == countdown_guard_pkg::ST_RUNNING && paused && !grant) |=> $stable(st_reg.count)) else $error("counted while paused");
  chk_wrap_flag: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == countdown_guard_pkg::ST_RUNNING && lf_tick && !paused && !grant &&
     st_reg.count == 32'h00000000) |=> st_reg.flag) else $error("no expiry on wrap");
  chk_delay_on_tick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == countdown_guard_pkg::ST_DELAY && !lf_tick) |=> st_reg.fsm == countdown_guard_pkg::ST_DELAY)
    else $error("delay left between ticks");
  chk_grant_keyed: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == countdown_guard_pkg::ST_RUNNING && grant) |->
    (psel && penable && pwrite && pwdata == countdown_guard_pkg::RELOAD_KEY)) else $error("grant without key");
  chk_pub_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    chan_publish_valid |=> !chan_publish_valid) else $error("publish pulse too long");
  chk_osc_stopped: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == countdown_guard_pkg::ST_STOPPED) |=> !rc_osc_force) else $error("osc forced when stopped");

  // **********************************************
  // Coverage
  // **********************************************
  cov_start: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(running));
  cov_grant: cover property (@(posedge ref_clk) disable iff (sys_rst) grant);
  cov_delay: cover property (@(posedge ref_clk) disable iff (sys_rst) st_reg.fsm == countdown_guard_pkg::ST_DELAY);
  cov_reset: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(wdt_reset_req));
  cov_pause: cover property (@(posedge ref_clk) disable iff (sys_rst)
    st_reg.fsm == countdown_guard_pkg::ST_RUNNING && paused && lf_tick);
endmodule : countdown_guard
`default_nettype wire

// File: logic/countdown_guard_pkg.sv
// Purpose: Constants shared by the countdown guard watchdog
// Assumes: 32-bit APB, 100 MHz ref_clk, low_freq_clock tick from a divider
// Notes:   Byte offsets match the register map
package countdown_guard_pkg;
  localparam logic [11:0] OFS_START     = 12'h000;
  localparam logic [11:0] OFS_SUB       = 12'h080;
  localparam logic [11:0] OFS_FLAG      = 12'h100;
  localparam logic [11:0] OFS_PUB       = 12'h180;
  localparam logic [11:0] OFS_IRQ_SET   = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h308;
  localparam logic [11:0] OFS_RUN       = 12'h400;
  localparam logic [11:0] OFS_REQ_STATE = 12'h404;
  localparam logic [11:0] OFS_CRV       = 12'h504;
  localparam logic [11:0] OFS_RELOAD_REQUEST_ENABLE      = 12'h508;
  localparam logic [11:0] OFS_PAUSE     = 12'h50C;
  localparam logic [11:0] OFS_RR_BASE   = 12'h600;
  localparam logic [11:0] OFS_RR_LAST   = 12'h61C;
  localparam int          RR_COUNT      = 8;
  localparam logic [31:0] RELOAD_KEY    = 32'h6E524635;
  localparam logic [31:0] CRV_RESET     = 32'hFFFFFFFF;
  localparam logic [7:0]  RELOAD_REQUEST_ENABLE_RESET    = 8'h01;
  localparam logic [1:0]  PAUSE_RESET   = 2'h3;
  localparam int          CH_EN_BIT     = 31;
  localparam int          PAUSE_SLEEP_BIT = 0;
  localparam int          PAUSE_HALT_BIT  = 1;
  localparam int          PAUSE_HALT_POS  = 3;
  localparam int          LF_HZ         = 32768;
  localparam int          REF_HZ        = 100000000;
  localparam int          LF_DIV        = REF_HZ / LF_HZ;
  localparam logic [1:0]  IRQ_RESET_DELAY = 2'h2;
  typedef enum logic [1:0] {
    ST_STOPPED = 2'b00,
    ST_RUNNING = 2'b01,
    ST_DELAY   = 2'b11,
    ST_RESET   = 2'b10
  } guard_state_e;
endpackage : countdown_guard_pkg

// File: logic/lf_tick_if.sv
// Purpose: Carries the low-frequency tick between divider and watchdog
// Assumes: Single ref_clk domain
// Notes:   Tick is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface lf_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : lf_tick_if
`default_nettype wire

// File: logic/lf_tick_div.sv
// Purpose: Divides ref_clk down to the low-frequency clock rate
// Assumes: DIV at least 2
// Notes:   Emits one enable pulse per low-frequency period
`timescale 1ns/10ps
`default_nettype none
module lf_tick_div #(
  parameter int DIV = countdown_guard_pkg::LF_DIV
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  lf_tick_if.src    lf
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } div_s;
  div_s st_reg;
  div_s st_next;
  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == DIV_LAST) begin
      st_next.cnt  = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign lf.tick = st_reg.tick;
endmodule : lf_tick_div
`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench for the countdown guard watchdog
// Assumes: Top keeps its default divider, so one tick is LF_DIV cycles
// Notes:   Small reload values keep each expiry short
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int DIV   = countdown_guard_pkg::LF_DIV;
  localparam int LIMIT = 100000;
  logic        ref_clk          = 1'b0;
  logic        sys_rst          = 1'b1;
  logic        psel             = 1'b0;
  logic        penable          = 1'b0;
  logic        pwrite           = 1'b0;
  logic [11:0] paddr            = 12'h000;
  logic [31:0] pwdata           = 32'h00000000;
  logic        cpu_sleeping     = 1'b0;
  logic        cpu_halted       = 1'b0;
  logic        other_lf_running = 1'b0;
  logic        chan_event_valid = 1'b0;
  logic [7:0]  chan_event_index = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        chan_publish_valid;
  logic [7:0]  chan_publish_index;
  logic        expiry_irq;
  logic        rc_osc_force;
  logic        wdt_reset_req;
  int          errors           = 0;
  int          check_count      = 0;
  int          cyc              = 0;
  int          pub_cnt          = 0;
  int          t_pub            = 0;
  int          t_rst            = -1;
  int          t0;
  int          p0;
  integer      seed             = 32'h81A3;
  logic [31:0] rd;
  logic        slv;
  logic [31:0] counter_reload_value;
  logic [7:0]  reload_request_enable;
  logic [7:0]  ch;
  logic [7:0]  pub_idx;

  countdown_guard i_countdown_guard (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_sleeping(cpu_sleeping), .cpu_halted(cpu_halted), .other_lf_running(other_lf_running),
    .chan_event_valid(chan_event_valid), .chan_event_index(chan_event_index),
    .chan_publish_valid(chan_publish_valid), .chan_publish_index(chan_publish_index),
    .expiry_irq(expiry_irq), .rc_osc_force(rc_osc_force), .wdt_reset_req(wdt_reset_req));

  always #5 ref_clk = ~ref_clk;

  // ****************************************
  // Monitor and timeout
  // ****************************************
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (chan_publish_valid === 1'b1) begin
      pub_cnt = pub_cnt + 1;
      t_pub = cyc;
      pub_idx = chan_publish_index;
    end
    if (wdt_reset_req === 1'b1 && t_rst < 0) t_rst = cyc;
    if (cyc == LIMIT) begin
      errors = errors + 1;
      results();
    end
  end

  // ****************************************
  // Tasks and expectation helpers
  // ****************************************
  function automatic logic [31:0] win(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 32'h00000001 : 32'h00000000;
  endfunction : win

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(name, rd, exp);
  endtask : rdchk

  task automatic do_reset;
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_rst = -1;
  endtask : do_reset

  task automatic pulse_event(input logic [7:0] idx);
    chan_event_valid <= 1'b1;
    chan_event_index <= idx;
    @(posedge ref_clk);
    chan_event_valid <= 1'b0;
    @(posedge ref_clk);
  endtask : pulse_event

  task automatic setup_run(input logic [31:0] c, input logic [31:0] pause);
    wr(countdown_guard_pkg::OFS_CRV, c);
    wr(countdown_guard_pkg::OFS_PAUSE, pause);
    wr(countdown_guard_pkg::OFS_PUB, 32'h80000000 | {24'h000000, ch});
    p0 = pub_cnt;
  endtask : setup_run

  task automatic wait_pub(input int n);
    t0 = cyc;
    while (pub_cnt == p0 && cyc < t0 + n) @(posedge ref_clk);
  endtask : wait_pub

  task automatic results;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    ch = 8'($random(seed));
    rdchk("crv rst", countdown_guard_pkg::OFS_CRV, countdown_guard_pkg::CRV_RESET);
    rdchk("reload_request_enable rst", countdown_guard_pkg::OFS_RELOAD_REQUEST_ENABLE, 32'h00000001);
    rdchk("pause rst", countdown_guard_pkg::OFS_PAUSE, 32'h00000009);
    rdchk("sub rst", countdown_guard_pkg::OFS_SUB, 32'h00000000);
    rdchk("pub rst", countdown_guard_pkg::OFS_PUB, 32'h00000000);
    rdchk("irq rst", countdown_guard_pkg::OFS_IRQ_SET, 32'h00000000);
    rdchk("run rst", countdown_guard_pkg::OFS_RUN, 32'h00000000);
    rdchk("state rst", countdown_guard_pkg::OFS_REQ_STATE, 32'h00000001);
    apb(1'b0, 12'h010, 32'h00000000);
    check("unmapped", {31'h0, slv}, 32'h00000001);
    // Default settings keep counting through sleep and halt
    cpu_sleeping <= 1'b1;
    cpu_halted <= 1'b1;
    counter_reload_value = $random(seed) & 32'h00000001;
    reload_request_enable = 8'($random(seed)) | 8'h81;
    wr(countdown_guard_pkg::OFS_RELOAD_REQUEST_ENABLE, {24'h000000, reload_request_enable});
    setup_run(counter_reload_value, 32'h00000009);
    wr(countdown_guard_pkg::OFS_START, 32'h00000001);
    rdchk("running", countdown_guard_pkg::OFS_RUN, 32'h00000001);
    check("osc force", {31'h0, rc_osc_force}, 32'h00000001);
    other_lf_running <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check("osc other", {31'h0, rc_osc_force}, 32'h00000000);
    other_lf_running <= 1'b0;
    wr(countdown_guard_pkg::OFS_CRV, 32'h00000005);
    wr(countdown_guard_pkg::OFS_RELOAD_REQUEST_ENABLE, 32'h000000FF);
    wr(countdown_guard_pkg::OFS_PAUSE, 32'h00000000);
    rdchk("crv lock", countdown_guard_pkg::OFS_CRV, counter_reload_value);
    rdchk("reload_request_enable lock", countdown_guard_pkg::OFS_RELOAD_REQUEST_ENABLE, {24'h000000, reload_request_enable});
    rdchk("pause lock", countdown_guard_pkg::OFS_PAUSE, 32'h00000009);
    for (int i = 0; i < 7; i++) wr(countdown_guard_pkg::OFS_RR_BASE + 12'(4 * i), countdown_guard_pkg::RELOAD_KEY);
    wr(countdown_guard_pkg::OFS_RR_LAST, 32'h12345678);
    rdchk("state part", countdown_guard_pkg::OFS_REQ_STATE, 32'h00000080);
    t0 = cyc;
    wr(countdown_guard_pkg::OFS_RR_LAST, countdown_guard_pkg::RELOAD_KEY);
    check("grant", win(pub_cnt - p0, 0, 0), 32'h00000001);
    rdchk("state clr", countdown_guard_pkg::OFS_REQ_STATE, {24'h000000, reload_request_enable});
    p0 = pub_cnt;
    wait_pub(3 * DIV);
    check("period", win(t_pub - t0, int'(counter_reload_value) * DIV, (int'(counter_reload_value) + 1) * DIV + 6), 32'h00000001);
    check("pub idx", {24'h000000, pub_idx}, {24'h000000, ch});
    repeat (4) @(posedge ref_clk);
    check("rst now", win(t_rst - t_pub, 0, 2), 32'h00000001);
    wr(countdown_guard_pkg::OFS_FLAG, 32'h00000000);
    wr(countdown_guard_pkg::OFS_IRQ_CLR, 32'h00000001);
    check("rst holds", {31'h0, wdt_reset_req}, 32'h00000001);
    // Interrupt enabled postpones the reset by two ticks
    cpu_sleeping <= 1'b0;
    cpu_halted <= 1'b0;
    do_reset();
    rdchk("run after rst", countdown_guard_pkg::OFS_RUN, 32'h00000000);
    wr(countdown_guard_pkg::OFS_IRQ_SET, 32'h00000001);
    wr(countdown_guard_pkg::OFS_IRQ_SET, 32'h00000000);
    rdchk("irq clr rd", countdown_guard_pkg::OFS_IRQ_CLR, 32'h00000001);
    wr(countdown_guard_pkg::OFS_IRQ_CLR, 32'h00000001);
    rdchk("irq off", countdown_guard_pkg::OFS_IRQ_SET, 32'h00000000);
    wr(countdown_guard_pkg::OFS_IRQ_SET, 32'h00000001);
    setup_run(32'h00000000, 32'h00000009);
    wr(countdown_guard_pkg::OFS_START, 32'h00000001);
    wait_pub(2 * DIV);
    repeat (3) @(posedge ref_clk);
    check("irq line", {31'h0, expiry_irq}, 32'h00000001);
    rdchk("flag", countdown_guard_pkg::OFS_FLAG, 32'h00000001);
    t0 = cyc;
    while (t_rst < 0 && cyc < t0 + 3 * DIV) @(posedge ref_clk);
    check("rst delay", win(t_rst - t_pub, 2 * DIV - 2, 2 * DIV + 3), 32'h00000001);
    // Sleep pause, then halt pause
    for (int m = 0; m < 2; m++) begin
      do_reset();
      setup_run(32'h00000000, (m == 0) ? 32'h00000008 : 32'h00000001);
      cpu_sleeping <= (m == 0);
      cpu_halted <= (m == 1);
      repeat (8) @(posedge ref_clk);
      wr(countdown_guard_pkg::OFS_START, 32'h00000001);
      repeat (3 * DIV) @(posedge ref_clk);
      check("paused", pub_cnt - p0, 32'h00000000);
      cpu_sleeping <= 1'b0;
      cpu_halted <= 1'b0;
      wait_pub(2 * DIV + 10);
      check("resumed", pub_cnt - p0, 32'h00000001);
    end
    // Start through an event channel
    do_reset();
    wr(countdown_guard_pkg::OFS_SUB, 32'h80000000 | {24'h000000, ch});
    rdchk("sub rd", countdown_guard_pkg::OFS_SUB, 32'h80000000 | {24'h000000, ch});
    pulse_event(ch ^ 8'h01);
    rdchk("no start", countdown_guard_pkg::OFS_RUN, 32'h00000000);
    pulse_event(ch);
    rdchk("ch start", countdown_guard_pkg::OFS_RUN, 32'h00000001);
    // Keep alive, then one missing key lets it expire
    do_reset();
    wr(countdown_guard_pkg::OFS_RELOAD_REQUEST_ENABLE, 32'h00000005);
    setup_run(32'h00000001, 32'h00000009);
    wr(countdown_guard_pkg::OFS_START, 32'h00000001);
    repeat (4) begin
      repeat (DIV - 60) @(posedge ref_clk);
      wr(countdown_guard_pkg::OFS_RR_BASE, countdown_guard_pkg::RELOAD_KEY);
      wr(countdown_guard_pkg::OFS_RR_BASE + 12'h008, countdown_guard_pkg::RELOAD_KEY);
    end
    check("kept alive", pub_cnt - p0, 32'h00000000);
    wr(countdown_guard_pkg::OFS_RR_BASE, countdown_guard_pkg::RELOAD_KEY);
    rdchk("state one", countdown_guard_pkg::OFS_REQ_STATE, 32'h00000004);
    wait_pub(3 * DIV);
    check("expired", pub_cnt - p0, 32'h00000001);
    results();
  end
endmodule : tb
`default_nettype wire
